/* File: rtl/ttxa_cfg.svh */
/*
 * Register offsets, field positions, reset values and fixed counts of the texel
 * addressing block. Assumes a byte-addressed plain register port, one word per register.
 */
`ifndef TTXA_CFG_SVH
`define TTXA_CFG_SVH

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define TTXA_REG_CONFIG 8'h00
`define TTXA_REG_STATUS 8'h04
`define TTXA_REG_PAL_INDEX 8'h08
`define TTXA_REG_PAL_DATA 8'h0C

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define TTXA_CFG_PALFMT_LSB 0
`define TTXA_CFG_STRIDE_LSB 8
`define TTXA_STS_ERRCNT_LSB 8
`define TTXA_PALFMT_RST 2'h0
`define TTXA_STRIDE_RST 5'h01

// ----------------------------------------------------------------------------
// Fixed counts
// ----------------------------------------------------------------------------
`define TTXA_SIZE_LOG_BASE 4'h3
`define TTXA_STRIDE_UNIT_LOG 5
`define TTXA_STRIDE_MAX 5'h10
`define TTXA_BUMP_FULL 9'h100
`define TTXA_PAL_DEPTH 1024

`endif

/* File: rtl/ttxa_pkg.sv */
/*
 * Types of the texel addressing block: formats, request word, state record.
 * Assumes the configuration header is compiled alongside.
 */
package ttxa_pkg;

    typedef enum logic [2:0] {
        PIX_1555 = 3'h0,
        PIX_565 = 3'h1,
        PIX_4444 = 3'h2,
        PIX_YUV = 3'h3,
        PIX_BUMP = 3'h4,
        PIX_PAL4 = 3'h5,
        PIX_PAL8 = 3'h6,
        PIX_BAD = 3'h7
    } ttxa_pix_t;

    typedef enum logic [1:0] {
        PF_1555 = 2'h0,
        PF_565 = 2'h1,
        PF_4444 = 2'h2,
        PF_8888 = 2'h3
    } ttxa_palfmt_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_PAL = 2'h3,
        ST_GAP = 2'h2
    } ttxa_state_t;

    // Per-polygon control plus the texel coordinate
    typedef struct packed {
        logic [20:0] base_word;
        logic scan_linear;
        logic stride_en;
        logic vq_en;
        logic mip_en;
        ttxa_pix_t pix_fmt;
        logic [5:0] pal_sel;
        logic [2:0] usize;
        logic [2:0] vsize;
        logic [1:0] filt;
        logic [9:0] u;
        logic [9:0] v;
    } ttxa_req_t;

    typedef struct packed {
        ttxa_state_t st;
        logic rdy;
        logic mem_req;
        logic [20:0] mem_addr;
        logic [3:0] sub;
        ttxa_pix_t fmt;
        logic linear;
        logic [5:0] pal_hi;
        logic slow;
        logic val;
        logic err;
        logic [31:0] texel;
        logic [8:0] bump_e;
        logic [8:0] bump_a;
        logic [9:0] pal_addr;
        ttxa_palfmt_t cfg_palfmt;
        logic [4:0] cfg_stride;
        logic [9:0] pal_idx;
        logic [7:0] err_cnt;
        logic [31:0] rdata;
    } ttxa_st_t;

endpackage : ttxa_pkg

/* File: rtl/ttxa_top.sv */
/*
 * Texel addressing and decoding: maps U/V to texture memory word addresses,
 * unpacks texels from 64-bit words, looks up and expands palette entries.
 * Assumes one outstanding memory read at a time, answered on the same clock.
 */
`timescale 1ns/1ps
`include "ttxa_cfg.svh"

module ttxa_top (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic req_valid_i,
    input wire ttxa_pkg::ttxa_req_t req_i,
    output logic req_ready_o,
    output logic mem_req_o,
    output logic [20:0] mem_addr_o,
    input wire logic mem_valid_i,
    input wire logic [63:0] mem_data_i,
    output logic texel_valid_o,
    output logic texel_err_o,
    output logic [31:0] texel_argb_o,
    output logic [8:0] bump_elev_o,
    output logic [8:0] bump_azim_o
);
    import ttxa_pkg::*;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Shorter axis sets how many bit pairs interleave
    function automatic logic [19:0] twiddle(input logic [9:0] u, input logic [9:0] v,
                                            input logic [3:0] ul, input logic [3:0] vl);
        logic [19:0] a;
        logic [3:0] m;
        a = '0;
        m = (ul < vl) ? ul : vl;
        for (int i = 0; i < 10; i++) begin
            if (i < int'(m)) begin
                a[2*i] = v[i];
                a[2*i+1] = u[i];
            end else if (ul > vl && i < int'(ul)) begin
                a[int'(m)+i] = u[i];
            end else if (vl > ul && i < int'(vl)) begin
                a[int'(m)+i] = v[i];
            end
        end
        return a;
    endfunction : twiddle

    // Low bits are zero-filled, save the 1555 alpha bit, which is replicated; colour bit replication is left to the colour stage
    function automatic logic [31:0] pal_expand(input ttxa_palfmt_t f, input logic [31:0] p);
        logic [31:0] r;
        r = p;
        unique case (f)
            PF_1555: r = {{8{p[15]}}, p[14:10], 3'h0, p[9:5], 3'h0, p[4:0], 3'h0};
            PF_565: r = {8'hFF, p[15:11], 3'h0, p[10:5], 2'h0, p[4:0], 3'h0};
            PF_4444: r = {p[15:12], 4'h0, p[11:8], 4'h0, p[7:4], 4'h0, p[3:0], 4'h0};
            PF_8888: r = p;
        endcase
        return r;
    endfunction : pal_expand

    function automatic logic [8:0] angle(input logic [7:0] c);
        return (c == 8'hFF) ? `TTXA_BUMP_FULL : {1'b0, c};
    endfunction : angle

    // ------------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------------
    ttxa_st_t s_q;
    ttxa_st_t s_d;
    logic [31:0] pal_ram [`TTXA_PAL_DEPTH];

    // Not reset: software loads entries before use
    always_ff @(posedge clk_sys_i) begin
        if (reg_wr_i && reg_addr_i == `TTXA_REG_PAL_DATA) begin
            pal_ram[s_q.pal_idx] <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------------------
    // Request decode and address
    // ------------------------------------------------------------------------
    logic taken;
    logic is_pal;
    logic bad;
    logic [3:0] ul;
    logic [3:0] vl;
    logic [19:0] tw_addr;
    logic [19:0] lin_addr;
    logic [19:0] str_addr;
    logic [19:0] taddr;
    logic [19:0] word;
    logic [3:0] sub;

    assign taken = req_valid_i && s_q.rdy;
    assign is_pal = req_i.pix_fmt == PIX_PAL4 || req_i.pix_fmt == PIX_PAL8;
    assign ul = {1'b0, req_i.usize} + `TTXA_SIZE_LOG_BASE;
    assign vl = {1'b0, req_i.vsize} + `TTXA_SIZE_LOG_BASE;
    assign tw_addr = twiddle(req_i.u, req_i.v, ul, vl);
    // Line length is the U size, rectangles too
    assign lin_addr = ({10'h0, req_i.v} << ul) + {10'h0, req_i.u};
    // 20 bits suffice: 16 x 32 x 1023 + 1023
    assign str_addr = (({15'h0, s_q.cfg_stride} * {10'h0, req_i.v}) << `TTXA_STRIDE_UNIT_LOG)
        + {10'h0, req_i.u};

    // Refused requests never reach memory
    always_comb begin
        bad = req_i.pix_fmt == PIX_BAD;
        if (req_i.scan_linear && (req_i.vq_en || req_i.mip_en)) begin
            bad = 1'b1;
        end
        if (req_i.scan_linear && is_pal) begin
            bad = 1'b1;
        end
        if (req_i.stride_en && (!req_i.scan_linear || s_q.cfg_stride == 5'h00
            || s_q.cfg_stride > `TTXA_STRIDE_MAX)) begin
            bad = 1'b1;
        end
    end

    always_comb begin
        if (req_i.scan_linear) begin
            taddr = req_i.stride_en ? str_addr : lin_addr;
        end else begin
            taddr = tw_addr;
        end
        if (req_i.pix_fmt == PIX_PAL4) begin
            word = taddr >> 4;
            sub = taddr[3:0];
        end else if (req_i.pix_fmt == PIX_PAL8) begin
            word = taddr >> 3;
            sub = {1'b0, taddr[2:0]};
        end else begin
            word = taddr >> 2;
            sub = {2'h0, taddr[1:0]};
        end
    end

    // ------------------------------------------------------------------------
    // Texel extraction from the returned word
    // ------------------------------------------------------------------------
    logic [15:0] cur_hw;
    logic [15:0] pair_hw;
    logic [1:0] pair_sub;
    logic own_left;
    logic [3:0] nib;
    logic [7:0] byt;

    // Left texel of a YUV pair sits in U-even slot: slot 0/1 interleaved, even slot linear
    assign pair_sub = s_q.linear ? (s_q.sub[1:0] ^ 2'h1)
        : (s_q.sub[1:0] ^ 2'h2);
    assign own_left = s_q.linear ? !s_q.sub[0] : !s_q.sub[1];
    assign cur_hw = mem_data_i[{s_q.sub[1:0], 4'h0} +: 16];
    assign pair_hw = mem_data_i[{pair_sub, 4'h0} +: 16];
    assign nib = mem_data_i[{s_q.sub, 2'h0} +: 4];
    assign byt = mem_data_i[{s_q.sub[2:0], 3'h0} +: 8];

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.mem_req = 1'b0;
        s_d.val = 1'b0;
        s_d.rdata = '0;

        if (reg_wr_i) begin
            unique case (reg_addr_i)
                `TTXA_REG_CONFIG: begin
                    s_d.cfg_palfmt = ttxa_palfmt_t'(reg_wdata_i[`TTXA_CFG_PALFMT_LSB +: 2]);
                    s_d.cfg_stride = reg_wdata_i[`TTXA_CFG_STRIDE_LSB +: 5];
                end
                `TTXA_REG_PAL_INDEX: s_d.pal_idx = reg_wdata_i[9:0];
                `TTXA_REG_PAL_DATA: s_d.pal_idx = s_q.pal_idx + 10'h001;
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                `TTXA_REG_CONFIG: begin
                    s_d.rdata[`TTXA_CFG_PALFMT_LSB +: 2] = s_q.cfg_palfmt;
                    s_d.rdata[`TTXA_CFG_STRIDE_LSB +: 5] = s_q.cfg_stride;
                end
                `TTXA_REG_STATUS: begin
                    s_d.rdata[1:0] = s_q.st;
                    s_d.rdata[2] = s_q.slow;
                    s_d.rdata[`TTXA_STS_ERRCNT_LSB +: 8] = s_q.err_cnt;
                end
                `TTXA_REG_PAL_INDEX: s_d.rdata[9:0] = s_q.pal_idx;
                `TTXA_REG_PAL_DATA: s_d.rdata = pal_ram[s_q.pal_idx];
                default: ;
            endcase
        end

        unique case (s_q.st)
            ST_IDLE: begin
                if (taken && bad) begin
                    // Refused request answers at once, no memory traffic
                    s_d.val = 1'b1;
                    s_d.err = 1'b1;
                    s_d.texel = '0;
                    s_d.err_cnt = s_q.err_cnt + 8'h01;
                end else if (taken) begin
                    s_d.st = ST_WAIT;
                    s_d.rdy = 1'b0;
                    s_d.mem_req = 1'b1;
                    s_d.mem_addr = req_i.base_word + {1'b0, word};
                    s_d.sub = sub;
                    s_d.fmt = req_i.pix_fmt;
                    s_d.linear = req_i.scan_linear;
                    s_d.pal_hi = req_i.pal_sel;
                    s_d.slow = is_pal && s_q.cfg_palfmt == PF_8888
                        && req_i.filt != 2'h0;
                    s_d.err = 1'b0;
                end
            end
            ST_WAIT: begin
                if (mem_valid_i) begin
                    if (s_q.fmt == PIX_PAL4) begin
                        s_d.pal_addr = {s_q.pal_hi, nib};
                        s_d.st = ST_PAL;
                    end else if (s_q.fmt == PIX_PAL8) begin
                        s_d.pal_addr = {s_q.pal_hi[5:4], byt};
                        s_d.st = ST_PAL;
                    end else begin
                        s_d.val = 1'b1;
                        s_d.texel = {16'h0, cur_hw};
                        // Own chroma byte from cur_hw, the other chroma byte from the pair's halfword
                        if (s_q.fmt == PIX_YUV) begin
                            s_d.texel = {8'h00, cur_hw[15:8], own_left ? cur_hw[7:0] : pair_hw[7:0],
                                own_left ? pair_hw[7:0] : cur_hw[7:0]};
                        end
                        s_d.bump_e = angle(cur_hw[15:8]);
                        s_d.bump_a = angle(cur_hw[7:0]);
                        s_d.st = ST_IDLE;
                        s_d.rdy = 1'b1;
                    end
                end
            end
            ST_PAL: begin
                s_d.val = 1'b1;
                s_d.texel = pal_expand(s_q.cfg_palfmt, pal_ram[s_q.pal_addr]);
                // A spare cycle stands in for the second fetch wide entries would cost
                s_d.st = s_q.slow ? ST_GAP : ST_IDLE;
                s_d.rdy = !s_q.slow;
            end
            ST_GAP: begin
                s_d.st = ST_IDLE;
                s_d.rdy = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            s_q <= '0;
            s_q.rdy <= 1'b1;
            s_q.cfg_palfmt <= ttxa_palfmt_t'(`TTXA_PALFMT_RST);
            s_q.cfg_stride <= `TTXA_STRIDE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // Data outputs hold, except reg_rdata_o, which clears after one cycle; valid pulses once
    assign reg_rdata_o = s_q.rdata;
    assign req_ready_o = s_q.rdy;
    assign mem_req_o = s_q.mem_req;
    assign mem_addr_o = s_q.mem_addr;
    assign texel_valid_o = s_q.val;
    assign texel_err_o = s_q.err;
    assign texel_argb_o = s_q.texel;
    assign bump_elev_o = s_q.bump_e;
    assign bump_azim_o = s_q.bump_a;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i);
    endclocking
    // Nothing checked while reset is held
    default disable iff (!resetn_i);

    AST_FETCH_ISSUED:
    assert property (taken && !bad |=> mem_req_o && !req_ready_o ##1 !mem_req_o)
        else $error("accepted request did not issue exactly one fetch");

    AST_TWID_LOW_BITS:
    assert property (taken && !bad && !req_i.scan_linear && req_i.pix_fmt == PIX_PAL4
        |=> s_q.sub[0] == $past(req_i.v[0]) && s_q.sub[1] == $past(req_i.u[0])
        && s_q.sub[2] == $past(req_i.v[1]))
        else $error("interleaved low address bits wrong");

    AST_LINEAR_128:
    assert property (taken && !bad && req_i.scan_linear && !req_i.stride_en && req_i.usize == 3'h4
        |=> mem_addr_o == $past(req_i.base_word) + {6'h0, $past(req_i.v), 5'h0}
        + {13'h0, $past(req_i.u[9:2])})
        else $error("linear 128-wide word address wrong");

    AST_STRIDE_REFUSED:
    assert property (taken && req_i.stride_en && req_i.scan_linear && s_q.cfg_stride == 5'h00
        |=> texel_valid_o && texel_err_o && !mem_req_o)
        else $error("zero stride was not refused");

    AST_LINEAR_PAL_REFUSED:
    assert property (taken && req_i.scan_linear && is_pal |=> texel_valid_o && texel_err_o)
        else $error("linear palette texture was not refused");

    AST_BUMP_FULL:
    assert property (s_q.st == ST_WAIT && mem_valid_i && s_q.fmt == PIX_BUMP
        && cur_hw[15:8] == 8'hFF
        |=> texel_valid_o && bump_elev_o == `TTXA_BUMP_FULL)
        else $error("elevation code 255 not taken as 256");

    AST_PAL4_ADDR:
    assert property (s_q.st == ST_WAIT && mem_valid_i && s_q.fmt == PIX_PAL4
        |=> s_q.st == ST_PAL && s_q.pal_addr[9:4] == $past(s_q.pal_hi) ##1 texel_valid_o)
        else $error("4-bit palette address or timing wrong");

    AST_PAL8_ADDR:
    assert property (s_q.st == ST_WAIT && mem_valid_i && s_q.fmt == PIX_PAL8
        |=> s_q.pal_addr[9:8] == $past(s_q.pal_hi[5:4]) && s_q.pal_addr[7:0] == $past(byt))
        else $error("8-bit palette address wrong");

    AST_SLOW_GAP:
    assert property (texel_valid_o && s_q.slow && !texel_err_o |-> !req_ready_o ##1 req_ready_o)
        else $error("half-rate gap missing");

    AST_565_OPAQUE:
    assert property (s_q.st == ST_PAL && s_q.cfg_palfmt == PF_565 |=> texel_argb_o[31:24] == 8'hFF)
        else $error("565 palette entry not opaque");

    AST_REFUSED_KEEPS_READY:
    assert property (taken && bad |=> req_ready_o && !mem_req_o)
        else $error("refused request fetched or dropped ready");

    COV_REFUSED: cover property (taken && bad);
    COV_TWIDDLE_RECT: cover property (taken && !bad && !req_i.scan_linear && req_i.usize != req_i.vsize);
    COV_STRIDE: cover property (taken && !bad && req_i.stride_en ##[1:20] texel_valid_o);
    COV_PAL_SLOW: cover property (s_q.st == ST_PAL && s_q.slow ##2 req_ready_o);
    COV_YUV: cover property (s_q.st == ST_WAIT && mem_valid_i && s_q.fmt == PIX_YUV);

endmodule : ttxa_top

/* File: tb/ttxa_mem_model.sv */
/*
 * Texture memory read port model: answers each word fetch after lat_i cycles.
 * Assumes one fetch in flight, lat_i of at least 1, synchronous active-low reset.
 */
`timescale 1ns/1ps
module ttxa_mem_model (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic [3:0] lat_i,
    input wire logic mem_req_i,
    input wire logic [20:0] mem_addr_i,
    output logic mem_valid_o,
    output logic [63:0] mem_data_o
);
    logic [20:0] addr_q = 21'h0;
    logic [3:0] cnt_q = 4'h0;

    // Contents follow from the address so the bench can predict every word
    function automatic logic [63:0] word_at(input logic [20:0] a);
        return {a[15:0] ^ 16'h1E2D, a[15:0] ^ 16'h3C4B, a[15:0] ^ 16'h5A69, a[15:0] ^ 16'h7887};
    endfunction : word_at

    always @(posedge clk_sys_i) begin
        mem_valid_o <= 1'b0;
        // Data lines flip outside the answer cycle, never hold a stale word
        mem_data_o <= ~mem_data_o;
        if (!resetn_i) begin
            cnt_q <= 4'h0;
            mem_data_o <= 64'h0;
        end else if (mem_req_i) begin
            addr_q <= mem_addr_i;
            cnt_q <= lat_i;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
                mem_valid_o <= 1'b1;
                mem_data_o <= word_at(addr_q);
            end
        end
    end
endmodule : ttxa_mem_model

/* File: tb/ttxa_top_tb.sv */
/*
 * Self-checking bench of the texel addressing block.
 * Assumes the memory model in ttxa_mem_model.sv on the fetch port.
 */
`timescale 1ns/1ps
`include "ttxa_cfg.svh"
module ttxa_top_tb;
    import ttxa_pkg::*;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic req_valid_i = 1'b0;
    ttxa_req_t req_i = '0;
    logic [31:0] reg_rdata_o, texel_argb_o;
    logic req_ready_o, mem_req_o, mem_valid_i, texel_valid_o, texel_err_o;
    logic [20:0] mem_addr_o;
    logic [63:0] mem_data_i;
    logic [8:0] bump_elev_o, bump_azim_o;
    logic [3:0] lat_q = 4'h1;
    ttxa_palfmt_t fmt_q = PF_1555;
    logic [4:0] stride_q = 5'h01;
    int err_count = 0;
    int tests_run = 0;

    ttxa_top ttxa_top_i (.clk_sys_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .req_valid_i, .req_i, .req_ready_o, .mem_req_o, .mem_addr_o, .mem_valid_i, .mem_data_i,
        .texel_valid_o, .texel_err_o, .texel_argb_o, .bump_elev_o, .bump_azim_o);
    ttxa_mem_model ttxa_mem_model_i (.clk_sys_i, .resetn_i, .lat_i(lat_q), .mem_req_i(mem_req_o),
        .mem_addr_i(mem_addr_o), .mem_valid_o(mem_valid_i), .mem_data_o(mem_data_i));

    initial begin
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------------
    // Shared tasks and predictions
    // ------------------------------------------------------------------
    task automatic close_out();
        $display("Checks run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        d = reg_rdata_o;
    endtask : reg_rd

    task automatic set_cfg(input ttxa_palfmt_t f, input logic [4:0] s);
        reg_wr(`TTXA_REG_CONFIG, {19'h0, s, 6'h0, f});
        fmt_q = f;
        stride_q = s;
    endtask : set_cfg

    function automatic logic [31:0] pal_val(input logic [9:0] p);
        return {~p[7:0], p[7:0], 6'h2B, p};
    endfunction : pal_val

    function automatic logic [31:0] expand(input logic [31:0] e, input ttxa_palfmt_t f);
        case (f)
            PF_1555: return {{8{e[15]}}, e[14:10], 3'h0, e[9:5], 3'h0, e[4:0], 3'h0};
            PF_565: return {8'hFF, e[15:11], 3'h0, e[10:5], 2'h0, e[4:0], 3'h0};
            PF_4444: return {e[15:12], 4'h0, e[11:8], 4'h0, e[7:4], 4'h0, e[3:0], 4'h0};
            default: return e;
        endcase
    endfunction : expand

    function automatic logic [19:0] texel_addr(input ttxa_req_t r);
        int ul, vl, m, a;
        ul = r.usize + 3;
        vl = r.vsize + 3;
        m = (ul < vl) ? ul : vl;
        a = 0;
        if (r.scan_linear && r.stride_en) return 20'(stride_q * 32 * r.v + r.u);
        if (r.scan_linear) return 20'((8 << r.usize) * r.v + r.u);
        for (int i = 0; i < m; i++) a |= (r.v[i] << (2 * i)) | (r.u[i] << (2 * i + 1));
        for (int i = m; i < ul; i++) a |= r.u[i] << (m + i);
        for (int i = m; i < vl; i++) a |= r.v[i] << (m + i);
        return 20'(a);
    endfunction : texel_addr

    function automatic ttxa_req_t mk(input ttxa_pix_t f, input logic lin, input logic [2:0] us,
                                     input logic [2:0] vs, input logic [9:0] u, input logic [9:0] v);
        ttxa_req_t r;
        r = '0;
        r.base_word = 21'h01000;
        r.pix_fmt = f;
        r.scan_linear = lin;
        r.usize = us;
        r.vsize = vs;
        r.u = u;
        r.v = v;
        return r;
    endfunction : mk

    task automatic run_req(input ttxa_req_t r, input logic exp_err);
        logic [19:0] ta;
        logic [20:0] wa, got;
        logic [63:0] w;
        logic [15:0] hw, yu, yv;
        logic [9:0] pa;
        logic [31:0] ex;
        logic pal, seen, rdy;
        int s, i;
        pal = (r.pix_fmt == PIX_PAL4) || (r.pix_fmt == PIX_PAL8);
        ta = texel_addr(r);
        wa = r.base_word + 21'(ta >> (r.pix_fmt == PIX_PAL4 ? 4 : pal ? 3 : 2));
        w = ttxa_mem_model_i.word_at(wa);
        s = ta[1:0];
        hw = w[16 * s +: 16];
        yu = w[16 * (r.scan_linear ? s & 2 : s & 1) +: 16];
        yv = w[16 * (r.scan_linear ? s | 1 : s | 2) +: 16];
        ex = (r.pix_fmt == PIX_YUV) ? {8'h00, hw[15:8], yu[7:0], yv[7:0]} : {16'h0, hw};
        pa = (r.pix_fmt == PIX_PAL4) ? {r.pal_sel, w[4 * ta[3:0] +: 4]} : {r.pal_sel[5:4], w[8 * ta[2:0] +: 8]};
        if (pal && !exp_err) reg_wr(`TTXA_REG_PAL_INDEX, {22'h0, pa});
        if (pal && !exp_err) reg_wr(`TTXA_REG_PAL_DATA, pal_val(pa));
        if (pal) ex = expand(pal_val(pa), fmt_q);
        seen = 1'b0;
        got = 21'h0;
        for (i = 0; i < 20 && req_ready_o !== 1'b1; i++) @(negedge clk_sys_i);
        @(posedge clk_sys_i);
        req_valid_i <= 1'b1;
        req_i <= r;
        @(posedge clk_sys_i);
        req_valid_i <= 1'b0;
        for (i = 0; i < 40 && texel_valid_o !== 1'b1; i++) begin
            @(negedge clk_sys_i);
            seen |= (mem_req_o === 1'b1);
            if (mem_req_o === 1'b1) got = mem_addr_o;
        end
        rdy = req_ready_o;
        check("texel_done", 1, i < 40);
        check("texel_err", exp_err, texel_err_o);
        check("fetch_seen", !exp_err, seen);
        if (!exp_err) check("fetch_addr", wa, got);
        if (!exp_err) check("texel_argb", ex, texel_argb_o);
        if (!exp_err) check("ready_at_result", !(pal && fmt_q == PF_8888 && r.filt != 2'h0), rdy);
        if (!exp_err && !pal) check("bump_elev", hw[15:8] == 8'hFF ? 9'h100 : {1'b0, hw[15:8]}, bump_elev_o);
        if (!exp_err && !pal) check("bump_azim", hw[7:0] == 8'hFF ? 9'h100 : {1'b0, hw[7:0]}, bump_azim_o);
    endtask : run_req

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic sc_regs();
        logic [31:0] d;
        check("ready_after_reset", 1, req_ready_o);
        reg_rd(`TTXA_REG_CONFIG, d);
        check("config_reset", 32'h0000_0100, d);
        @(negedge clk_sys_i);
        check("rdata_one_cycle", 0, reg_rdata_o);
        reg_wr(8'h40, 32'hFFFF_FFFF);
        reg_rd(8'h40, d);
        check("unmapped_read", 0, d);
        reg_rd(`TTXA_REG_STATUS, d);
        check("status_reset", 0, d);
        reg_wr(`TTXA_REG_PAL_INDEX, 32'h0000_03FF);
        reg_wr(`TTXA_REG_PAL_DATA, 32'hA1B2_C3D4);
        reg_wr(`TTXA_REG_PAL_INDEX, 32'h0000_03FF);
        reg_rd(`TTXA_REG_PAL_DATA, d);
        check("palette_top_entry", 32'hA1B2_C3D4, d);
    endtask : sc_regs

    task automatic sc_shapes();
        int n;
        for (int k = 0; k < 8; k++) begin
            n = 8 << k;
            run_req(mk(ttxa_pix_t'(k % 4), 1'b0, 3'(k), 3'(k), 10'(n - 3), 10'(n / 2 + 2)), 1'b0);
        end
        run_req(mk(PIX_565, 1'b0, 3'h0, 3'h3, 10'h005, 10'h02B), 1'b0);
        run_req(mk(PIX_BUMP, 1'b0, 3'h5, 3'h1, 10'h0B7, 10'h009), 1'b0);
        lat_q = 4'h5;
        run_req(mk(PIX_4444, 1'b1, 3'h4, 3'h2, 10'h007, 10'h001), 1'b0);
        run_req(mk(PIX_YUV, 1'b1, 3'h4, 3'h4, 10'h006, 10'h003), 1'b0);
        run_req(mk(PIX_YUV, 1'b1, 3'h4, 3'h4, 10'h005, 10'h07F), 1'b0);
        run_req(mk(PIX_1555, 1'b1, 3'h0, 3'h7, 10'h003, 10'h3FF), 1'b0);
        lat_q = 4'h1;
    endtask : sc_shapes

    task automatic sc_stride_refuse();
        ttxa_req_t r;
        logic [31:0] d, d0;
        reg_rd(`TTXA_REG_STATUS, d0);
        r = mk(PIX_565, 1'b1, 3'h0, 3'h0, 10'h07B, 10'h022);
        r.stride_en = 1'b1;
        set_cfg(PF_1555, 5'h04);
        run_req(r, 1'b0);
        set_cfg(PF_1555, 5'h10);
        run_req(r, 1'b0);
        set_cfg(PF_1555, 5'h11);
        run_req(r, 1'b1);
        set_cfg(PF_1555, 5'h00);
        run_req(r, 1'b1);
        set_cfg(PF_1555, 5'h01);
        r.scan_linear = 1'b0;
        run_req(r, 1'b1);
        r = mk(PIX_565, 1'b1, 3'h2, 3'h2, 10'h003, 10'h004);
        r.vq_en = 1'b1;
        run_req(r, 1'b1);
        r.scan_linear = 1'b0;
        run_req(r, 1'b0);
        r = mk(PIX_565, 1'b1, 3'h2, 3'h2, 10'h003, 10'h004);
        r.mip_en = 1'b1;
        run_req(r, 1'b1);
        run_req(mk(PIX_PAL4, 1'b1, 3'h2, 3'h2, 10'h001, 10'h002), 1'b1);
        run_req(mk(PIX_PAL8, 1'b1, 3'h2, 3'h2, 10'h001, 10'h002), 1'b1);
        run_req(mk(PIX_BAD, 1'b0, 3'h2, 3'h2, 10'h001, 10'h002), 1'b1);
        reg_rd(`TTXA_REG_STATUS, d);
        check("refused_count", 8'(d0[15:8] + 8'h08), d[15:8]);
    endtask : sc_stride_refuse

    task automatic sc_bump_palette();
        ttxa_req_t r;
        r = mk(PIX_BUMP, 1'b1, 3'h0, 3'h0, 10'h000, 10'h000);
        r.base_word = 21'h08787;
        run_req(r, 1'b0);
        r.base_word = 21'h07878;
        run_req(r, 1'b0);
        for (int f = 0; f < 4; f++) begin
            set_cfg(ttxa_palfmt_t'(f), 5'h01);
            r = mk(PIX_PAL4, 1'b0, 3'h3, 3'h2, 10'h03D, 10'h01E);
            r.pal_sel = 6'h3F;
            r.filt = 2'h1;
            run_req(r, 1'b0);
            r.pix_fmt = PIX_PAL8;
            r.pal_sel = 6'h2A;
            r.filt = 2'(f & 1);
            run_req(r, 1'b0);
        end
        set_cfg(PF_1555, 5'h01);
    endtask : sc_bump_palette

    initial begin
        #(25 * 20000);
        err_count++;
        close_out();
    end

    initial begin
        repeat (6) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(negedge clk_sys_i);
        sc_regs();
        sc_shapes();
        sc_stride_refuse();
        sc_bump_palette();
        close_out();
    end
endmodule : ttxa_top_tb
